// >>> logic/itb_cfg.svh
// Constants for the interval timer bus and control block.
`ifndef ITB_CFG_SVH
`define ITB_CFG_SVH
`define ITB_ADDR_CTRL     2'h3
`define ITB_CW_SEL_HI     7
`define ITB_CW_SEL_LO     6
`define ITB_CW_ORD_HI     5
`define ITB_CW_ORD_LO     4
`define ITB_CW_MODE_HI    3
`define ITB_CW_MODE_LO    1
`define ITB_CW_BCD        0
`define ITB_SEL_ILLEGAL   2'h3
`define ITB_ORD_LATCH     2'h0
`define ITB_ORD_LSB       2'h1
`define ITB_ORD_MSB       2'h2
`define ITB_ORD_BOTH      2'h3
`define ITB_CW_RESET      6'h00
`endif

// >>> logic/itb_pkg.sv
// Types shared by the interval timer files.
package itb_pkg;
    typedef enum logic [2:0] {
        ITB_M0, ITB_M1, ITB_M2, ITB_M3, ITB_M4, ITB_M5
    } itb_mode_t;
    typedef enum logic [1:0] {
        ITB_ST_IDLE, ITB_ST_WAIT_HI, ITB_ST_ARM, ITB_ST_RUN
    } itb_state_t;
endpackage

// >>> logic/itb_counter.sv
// One counter channel: 16-bit down counter with mode-driven output.
`include "itb_cfg.svh"
module itb_counter
    import itb_pkg::*;
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Configuration.
    input  wire itb_pkg::itb_mode_t mode,
    input  wire logic             bcd,
    input  wire logic             cfg_wr,
    input  wire logic             stop,
    input  wire logic             load,
    input  wire logic [15:0]      load_val,
    // Counter pins, sampled synchronously.
    input  wire logic             cnt_clk,
    input  wire logic             gate,
    output logic                  out,
    output logic [15:0]           count
);
    logic [15:0] cnt_reg, cnt_next, init_reg, init_next;
    logic        out_reg, out_next, run_reg, run_next, pend_reg, pend_next;
    logic        cclk_reg, gate_reg;
    logic        fall, gate_rise;

    // Decrement by one or two in binary or four-decade decimal.
    function automatic logic [15:0] dec_val(input logic [15:0] v, input logic b,
                                            input logic [1:0] s);
        logic [15:0] r;
        r = v;
        for (int k = 0; k < 3; k++) begin
            if (k < int'(s)) begin
                if (!b) begin
                    r = r - 16'h0001;
                end else begin
                    r = r - 16'h0001;
                    if (r[3:0] == 4'hf) r[3:0] = 4'h9;
                    if (r[7:4] == 4'hf) r[7:4] = 4'h9;
                    if (r[11:8] == 4'hf) r[11:8] = 4'h9;
                    if (r[15:12] == 4'hf) r[15:12] = 4'h9;
                end
            end
        end
        return r;
    endfunction

    assign fall      = cclk_reg & ~cnt_clk;
    assign gate_rise = gate & ~gate_reg;
    assign out       = out_reg;
    assign count     = cnt_reg;

    // Next-state logic for count, output and pending load.
    always_comb begin
        cnt_next  = cnt_reg;
        init_next = init_reg;
        out_next  = out_reg;
        run_next  = run_reg;
        pend_next = pend_reg | load;
        if (load) init_next = load_val;
        if (cfg_wr) begin
            out_next  = (mode != ITB_M0);
            run_next  = 1'b0;
            pend_next = 1'b0;
        end else if (stop && mode == ITB_M0) begin
            run_next = 1'b0;
        end else if (fall) begin
            if (pend_reg && (mode == ITB_M0 || mode == ITB_M4 || !run_reg)) begin
                cnt_next  = init_next;
                pend_next = 1'b0;
                run_next  = 1'b1;
                if (mode == ITB_M0) out_next = 1'b0;
            end else if ((mode == ITB_M1 || mode == ITB_M5) && gate_rise) begin
                cnt_next = init_reg;
                run_next = 1'b1;
                if (mode == ITB_M1) out_next = 1'b0;
            end else if ((mode == ITB_M2 || mode == ITB_M3) && !gate) begin
                out_next = 1'b1;
                cnt_next = init_reg;
            end else if (run_reg && (gate || mode == ITB_M1 || mode == ITB_M5)) begin
                case (mode)
                    ITB_M2: begin
                        // Low only while at count one, then reload, so a period is N clocks.
                        cnt_next = (cnt_reg == 16'h0001) ? init_reg
                                                         : dec_val(cnt_reg, bcd, 2'd1);
                        out_next = (cnt_reg != 16'h0002);
                    end
                    ITB_M3: begin
                        if (cnt_reg <= 16'h0002) begin
                            cnt_next = init_reg;
                            out_next = ~out_reg;
                        end else begin
                            cnt_next = dec_val(cnt_reg, bcd, cnt_reg[0] ? 2'd1 : 2'd2);
                        end
                    end
                    default: begin
                        cnt_next = dec_val(cnt_reg, bcd, 2'd1);
                        if (cnt_reg == 16'h0001) begin
                            out_next = (mode == ITB_M0 || mode == ITB_M1);
                        end else if (mode == ITB_M4 || mode == ITB_M5) begin
                            out_next = 1'b1;
                        end
                    end
                endcase
            end else if (mode == ITB_M4 || mode == ITB_M5) begin
                out_next = 1'b1;
            end
        end
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= 16'h0000;
            init_reg <= 16'h0000;
            out_reg  <= 1'b0;
            run_reg  <= 1'b0;
            pend_reg <= 1'b0;
            cclk_reg <= 1'b0;
            gate_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            init_reg <= init_next;
            out_reg  <= out_next;
            run_reg  <= run_next;
            pend_reg <= pend_next;
            cclk_reg <= cnt_clk;
            gate_reg <= gate;
        end
    end

    AST_MODE0_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && mode == ITB_M0) |=> !out) else $error("mode 0 output not low");
    AST_MODE2_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == ITB_M2 && !out && fall && !cfg_wr) |=> out) else $error("m2 pulse");
endmodule

// >>> logic/itb_top.sv
// Bus interface, control word decode and three timer channels.
`include "itb_cfg.svh"
module itb_top
    import itb_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Processor bus.
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        port_sel_0,
    input  wire logic        port_sel_1,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    // Counter pins.
    input  wire logic [2:0]  cnt_clk,
    input  wire logic [2:0]  gate,
    output logic      [2:0]  cnt_out
);
    import itb_pkg::*;

    itb_mode_t   mode_reg [3], mode_next [3];
    logic [2:0]  bcd_reg, bcd_next;
    logic [1:0]  ord_reg [3], ord_next [3];
    logic [2:0]  lhi_reg, lhi_next, rhi_reg, rhi_next, lat_reg, lat_next;
    logic [15:0] ldat_reg [3], ldat_next [3], lat_val_reg [3], lat_val_next [3];
    logic [2:0]  cfg_wr, stop, load;
    logic [2:0]  cfg_wr_reg;
    logic [15:0] load_val [3];
    logic [15:0] count [3];
    logic [2:0]  out_w;
    logic [7:0]  dout_reg, dout_next;
    logic        oe_reg, oe_next, wr_d, rd_d;
    logic [1:0]  addr;
    logic        wr_acc, rd_acc, rd_end;
    logic [7:0]  cw;

    // Decode a mode field; top bit ignored for modes 2 and 3.
    function automatic itb_mode_t mode_dec(input logic [2:0] m);
        case (m)
            3'h0: return ITB_M0;
            3'h1: return ITB_M1;
            3'h4: return ITB_M4;
            3'h5: return ITB_M5;
            default: return m[0] ? ITB_M3 : ITB_M2;
        endcase
    endfunction

    assign addr   = {port_sel_1, port_sel_0};
    assign wr_acc = !cs_n && !wr_n && rd_n && wr_d;
    assign rd_acc = !cs_n && !rd_n && wr_n;
    assign rd_end = rd_d && (rd_n || cs_n);
    assign cw     = data_in;
    assign data_out = dout_reg;
    assign data_oe  = oe_reg;
    assign cnt_out  = out_w;

    // Bus access next state per channel.
    always_comb begin
        bcd_next = bcd_reg; lhi_next = lhi_reg; rhi_next = rhi_reg;
        lat_next = lat_reg;
        cfg_wr = 3'h0; stop = 3'h0; load = 3'h0;
        for (int i = 0; i < 3; i++) begin
            mode_next[i] = mode_reg[i];
            ord_next[i] = ord_reg[i];
            ldat_next[i] = ldat_reg[i];
            lat_val_next[i] = lat_val_reg[i];
            load_val[i] = ldat_reg[i];
            // Read completion first, so a latch or mode write in the same cycle wins.
            if (rd_end && addr == 2'(i)) begin
                if (ord_reg[i] == `ITB_ORD_BOTH) rhi_next[i] = ~rhi_reg[i];
                if (ord_reg[i] != `ITB_ORD_BOTH || rhi_reg[i]) lat_next[i] = 1'b0;
            end
            if (wr_acc && addr == `ITB_ADDR_CTRL && cw[7:6] == 2'(i)) begin
                if (cw[5:4] == `ITB_ORD_LATCH) begin
                    lat_next[i] = 1'b1;
                    lat_val_next[i] = count[i];
                end else begin
                    ord_next[i] = cw[5:4];
                    mode_next[i] = mode_dec(cw[3:1]);
                    bcd_next[i] = cw[`ITB_CW_BCD];
                    cfg_wr[i] = 1'b1;
                    lhi_next[i] = 1'b0;
                    rhi_next[i] = 1'b0;
                    lat_next[i] = 1'b0;
                end
            end
            if (wr_acc && addr == 2'(i)) begin
                case (ord_reg[i])
                    `ITB_ORD_LSB: begin load_val[i] = {8'h00, cw}; load[i] = 1'b1; end
                    `ITB_ORD_MSB: begin load_val[i] = {cw, 8'h00}; load[i] = 1'b1; end
                    default: begin
                        if (!lhi_reg[i]) begin
                            ldat_next[i][7:0] = cw;
                            stop[i] = 1'b1;
                        end else begin
                            load_val[i] = {cw, ldat_reg[i][7:0]};
                            load[i] = 1'b1;
                        end
                        lhi_next[i] = ~lhi_reg[i];
                    end
                endcase
            end
        end
    end

    // Read data path; control word address never drives the bus.
    always_comb begin
        logic [15:0] v;
        v = 16'h0000;
        dout_next = 8'h00;
        oe_next = rd_acc && addr != `ITB_ADDR_CTRL;
        for (int i = 0; i < 3; i++) begin
            if (addr == 2'(i)) begin
                v = lat_reg[i] ? lat_val_reg[i] : count[i];
                dout_next = (ord_reg[i] == `ITB_ORD_MSB ||
                            (ord_reg[i] == `ITB_ORD_BOTH && rhi_reg[i])) ? v[15:8] : v[7:0];
            end
        end
    end

    // Bus and configuration registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                mode_reg[i] <= ITB_M0;
                ord_reg[i] <= `ITB_ORD_BOTH;
                ldat_reg[i] <= 16'h0000;
                lat_val_reg[i] <= 16'h0000;
            end
            bcd_reg <= 3'h0; lhi_reg <= 3'h0; rhi_reg <= 3'h0; lat_reg <= 3'h0;
            dout_reg <= 8'h00; oe_reg <= 1'b0; wr_d <= 1'b1; rd_d <= 1'b0;
            cfg_wr_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                mode_reg[i] <= mode_next[i];
                ord_reg[i] <= ord_next[i];
                ldat_reg[i] <= ldat_next[i];
                lat_val_reg[i] <= lat_val_next[i];
            end
            bcd_reg <= bcd_next; lhi_reg <= lhi_next; rhi_reg <= rhi_next;
            lat_reg <= lat_next;
            dout_reg <= dout_next; oe_reg <= oe_next;
            wr_d <= wr_n | cs_n;
            rd_d <= rd_acc;
            // Mode pulse is registered to land in the same cycle as the mode register, so the channel acts on the new mode.
            cfg_wr_reg <= cfg_wr;
        end
    end

    // Three independent channels, unaffected by the select input.
    for (genvar g = 0; g < 3; g++) begin : g_ch
        itb_counter u_cnt (
            .clk      (clk),
            .rst_n    (rst_n),
            .mode     (mode_reg[g]),
            .bcd      (bcd_reg[g]),
            .cfg_wr   (cfg_wr_reg[g]),
            .stop     (stop[g]),
            .load     (load[g]),
            .load_val (load_val[g]),
            .cnt_clk  (cnt_clk[g]),
            .gate     (gate[g]),
            .out      (out_w[g]),
            .count    (count[g])
        );
    end

    AST_DESEL_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        cs_n |=> !data_oe) else $error("bus driven while deselected");
    AST_CTRL_NOREAD: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_acc && addr == 2'h3) |=> !data_oe) else $error("control word read drove bus");
    AST_IDLE_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_n && wr_n) |=> !data_oe) else $error("bus driven while idle");
    AST_READ_DRIVES: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_acc && addr != 2'h3) |=> data_oe) else $error("read not answered");
    AST_ILLEGAL_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_acc && addr == 2'h3 && cw[7:6] == 2'h3) |-> cfg_wr == 3'h0) else $error("illegal sel");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (lat_reg[0] && !cfg_wr[0] && !wr_acc) |=> $stable(lat_val_reg[0])) else $error("latch moved");
    COV_READ: cover property (@(posedge clk) rd_acc);
    COV_LATCH: cover property (@(posedge clk) lat_reg[0]);
    COV_LOAD: cover property (@(posedge clk) load[0]);
endmodule

// >>> sim/itb_cpu.sv
// Processor model driving the timer's register bus.
module itb_cpu (
    // Clock.
    input  wire logic       clk,
    // Bus towards the timer.
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            port_sel_0,
    output logic            port_sel_1,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero.
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        {port_sel_1, port_sel_0} = 2'h0;
        data_in = 8'h00;
    end

    // One write strobe; a released bus shows the inverse of the last byte.
    task automatic bus_write(input logic sel, input logic [1:0] addr, input logic [7:0] val);
        @(posedge clk);
        cs_n <= ~sel;
        wr_n <= 1'b0;
        {port_sel_1, port_sel_0} <= addr;
        data_in <= val;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        data_in <= ~val;
        @(posedge clk);
    endtask

    // One read strobe; data and enable are taken at the last held edge.
    task automatic bus_read(input logic sel, input logic [1:0] addr,
                            output logic [7:0] val, output logic oe);
        @(posedge clk);
        cs_n <= ~sel;
        rd_n <= 1'b0;
        {port_sel_1, port_sel_0} <= addr;
        repeat (3) @(posedge clk);
        val = data_out;
        oe = data_oe;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clk);
    endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the interval timer bus and control block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       rst_n;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       port_sel_0;
    logic       port_sel_1;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic       data_oe;
    logic [2:0] cnt_clk;
    logic [2:0] gate;
    logic [2:0] cnt_out;
    int         mismatches;
    int         check_count;
    logic [15:0] v;
    logic [7:0] b;
    logic       oe;

    itb_top u_itb_top (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .port_sel_0(port_sel_0), .port_sel_1(port_sel_1), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .cnt_clk(cnt_clk), .gate(gate),
        .cnt_out(cnt_out));
    itb_cpu u_itb_cpu (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .port_sel_0(port_sel_0), .port_sel_1(port_sel_1), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));

    // Free-running system clock of 8 ns.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Reports the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compares a seen value against the expected one.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Gives one counter n full clock pulses.
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            @(posedge clk);
            cnt_clk[ch] <= 1'b1;
            repeat (2) @(posedge clk);
            cnt_clk[ch] <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    // Control word, count bytes by order, then one counter clock to load.
    task automatic prog(input logic [1:0] ch, input logic [1:0] ord, input logic [2:0] md,
                        input logic bcd, input logic [15:0] val);
        u_itb_cpu.bus_write(1'b1, 2'h3, {ch, ord, md, bcd});
        if (ord[0]) u_itb_cpu.bus_write(1'b1, ch, val[7:0]);
        if (ord[1]) u_itb_cpu.bus_write(1'b1, ch, val[15:8]);
        pulse(ch, 1);
    endtask

    // Latch command, then the bytes that the order names.
    task automatic read_cnt(input logic [1:0] ch, input logic [1:0] ord, output logic [15:0] r);
        r = 16'h0000;
        u_itb_cpu.bus_write(1'b1, 2'h3, {ch, 6'h00});
        if (ord[0]) begin
            u_itb_cpu.bus_read(1'b1, ch, b, oe);
            r[7:0] = b;
        end
        if (ord[1]) begin
            u_itb_cpu.bus_read(1'b1, ch, b, oe);
            r[15:8] = b;
        end
        check("read drive", {15'h0, oe}, 16'h0001);
    endtask

    // Bus floats for control word reads and deselected reads.
    task automatic t_float();
        check("reset oe", {15'h0, data_oe}, 16'h0000);
        u_itb_cpu.bus_read(1'b1, 2'h3, b, oe);
        check("ctrl read oe", {15'h0, oe}, 16'h0000);
        u_itb_cpu.bus_read(1'b0, 2'h0, b, oe);
        check("desel read oe", {15'h0, oe}, 16'h0000);
    endtask

    // Byte orders, deselected and illegal writes, radix and independence.
    task automatic t_loads();
        prog(2'h1, 2'h3, 3'h2, 1'b0, 16'h1234);
        read_cnt(2'h1, 2'h3, v);
        check("both bytes", v, 16'h1234);
        prog(2'h2, 2'h2, 3'h0, 1'b0, 16'h5600);
        u_itb_cpu.bus_write(1'b0, 2'h2, 8'h99);
        u_itb_cpu.bus_write(1'b1, 2'h3, 8'hd4);
        pulse(2, 1);
        read_cnt(2'h2, 2'h2, v);
        check("msb only", v, 16'h5500);
        prog(2'h0, 2'h1, 3'h0, 1'b0, 16'h0078);
        read_cnt(2'h0, 2'h1, v);
        check("lsb only", v, 16'h0078);
        prog(2'h0, 2'h3, 3'h0, 1'b1, 16'h0010);
        pulse(0, 1);
        read_cnt(2'h0, 2'h3, v);
        check("bcd step", v, 16'h0009);
        read_cnt(2'h1, 2'h3, v);
        check("other held", v, 16'h1234);
    endtask

    // Terminal count in mode 0 and the rate in mode 2.
    task automatic t_modes();
        int first;
        int gap;
        first = -1;
        gap = 0;
        prog(2'h0, 2'h1, 3'h0, 1'b0, 16'h0003);
        pulse(0, 2);
        check("mode0 low", {15'h0, cnt_out[0]}, 16'h0000);
        pulse(0, 3);
        check("mode0 high", {15'h0, cnt_out[0]}, 16'h0001);
        prog(2'h1, 2'h1, 3'h2, 1'b0, 16'h0004);
        for (int i = 0; i < 16; i++) begin
            pulse(1, 1);
            if (cnt_out[1] === 1'b0 && first >= 0 && gap == 0) gap = i - first;
            if (cnt_out[1] === 1'b0 && first < 0) first = i;
        end
        check("mode2 period", gap[15:0], 16'h0004);
        for (int m = 0; m < 8; m++) begin
            u_itb_cpu.bus_write(1'b1, 2'h3, {4'hb, m[2:0], 1'b0});
            repeat (3) @(posedge clk);
            check("mode set out", {15'h0, cnt_out[2]}, {15'h0, m != 0});
        end
    endtask

    // Main sequence after an eight-cycle reset.
    initial begin
        rst_n = 1'b0;
        cnt_clk = 3'h0;
        gate = 3'h7;
        mismatches = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_float();
        t_loads();
        t_modes();
        finish_test();
    end

    // Watchdog far beyond the expected run length.
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule
